// *** verilog/interrupt_latch_enable_unit.sv ***
`timescale 1ns/10ps
module interrupt_latch_enable_unit (
  // Clock and reset
  input  wire logic                          sys_clk,
  input  wire logic                          sys_rst,
  // Special-function byte access
  input  wire logic [7:0]                    sfr_addr,
  input  wire logic                          sfr_wr,
  input  wire logic                          sfr_rd,
  input  wire logic [7:0]                    sfr_wdata,
  output logic      [7:0]                    sfr_rdata,
  output logic                               sfr_hit,
  // Interrupt sources
  input  wire logic [intc_pkg::NUM_SRC-1:0]  src_req,
  input  wire logic                          swi_req,
  input  wire logic                          undef_req,
  // Core instruction sequencer
  input  wire logic                          instr_last_cycle,
  input  wire logic                          machine_cycle_tick,
  input  wire logic                          accept,
  input  wire logic [intc_pkg::IDX_W-1:0]    accept_index,
  input  wire logic                          unmask_all_instr,
  input  wire logic                          mask_all_instr,
  input  wire logic                          return_instr,
  input  wire logic                          restored_master,
  // Requests and status towards the core
  output logic                               irq_request,
  output logic [intc_pkg::IDX_W-1:0]         irq_index,
  output logic                               irq_sampled,
  output logic [intc_pkg::IDX_W-1:0]         irq_sampled_index,
  output logic                               saved_master,
  output logic                               accept_busy,
  output logic                               master_enable
);

  ////////////////////////////////////////////////////////////////////////////////
  // Byte lane helpers

  function automatic logic [31:0] lane_of(input logic [7:0] addr,
                                          input logic [7:0] lo_l,
                                          input logic [7:0] lo_h,
                                          input logic [7:0] hi_l,
                                          input logic [7:0] hi_h,
                                          input logic [7:0] data,
                                          input logic [7:0] fill);
    logic [31:0] word;
    word = {4{fill}};
    if (addr == lo_l) begin
      word[7:0] = data;
    end else if (addr == lo_h) begin
      word[15:8] = data;
    end else if (addr == hi_l) begin
      word[23:16] = data;
    end else if (addr == hi_h) begin
      word[31:24] = data;
    end
    return word;
  endfunction

  function automatic logic [7:0] pick_byte(input logic [7:0]  addr,
                                           input logic [7:0]  lo_l,
                                           input logic [7:0]  lo_h,
                                           input logic [7:0]  hi_l,
                                           input logic [7:0]  hi_h,
                                           input logic [31:0] word);
    logic [7:0] b;
    b = 8'h00;
    if (addr == lo_l) begin
      b = word[7:0];
    end else if (addr == lo_h) begin
      b = word[15:8];
    end else if (addr == hi_l) begin
      b = word[23:16];
    end else if (addr == hi_h) begin
      b = word[31:24];
    end
    return b;
  endfunction

  function automatic logic is_group(input logic [7:0] addr,
                                    input logic [7:0] lo_l,
                                    input logic [7:0] lo_h,
                                    input logic [7:0] hi_l,
                                    input logic [7:0] hi_h);
    return (addr == lo_l) || (addr == lo_h) || (addr == hi_l) || (addr == hi_h);
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Address decode

  logic pend_sel;
  logic en_sel;

  always_comb begin
    pend_sel = is_group(sfr_addr, intc_pkg::ADDR_PEND_LO_L, intc_pkg::ADDR_PEND_LO_H,
                        intc_pkg::ADDR_PEND_HI_L, intc_pkg::ADDR_PEND_HI_H);
    en_sel   = is_group(sfr_addr, intc_pkg::ADDR_EN_LO_L, intc_pkg::ADDR_EN_LO_H,
                        intc_pkg::ADDR_EN_HI_L, intc_pkg::ADDR_EN_HI_H);
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Pending latches

  logic [31:0] latch_reg;
  logic [31:0] latch_next;
  logic [31:0] latch_set;
  logic [31:0] latch_clr;
  logic [31:0] wr_keep;
  logic [31:0] accept_onehot;

  always_comb begin
    // A write leaves every bit outside the addressed byte at one, i.e. untouched.
    wr_keep = lane_of(sfr_addr, intc_pkg::ADDR_PEND_LO_L, intc_pkg::ADDR_PEND_LO_H,
                      intc_pkg::ADDR_PEND_HI_L, intc_pkg::ADDR_PEND_HI_H,
                      sfr_wdata, 8'hff);
    accept_onehot = 32'h0000_0000;
    if (accept) begin
      accept_onehot[accept_index] = 1'b1;
    end
    latch_set = src_req & intc_pkg::LATCH_MASK;
    latch_clr = accept_onehot;
    if (sfr_wr && pend_sel) begin
      latch_clr = latch_clr | ~wr_keep;
    end
    // A request in the same cycle as a clear wins, so no event is lost.
    latch_next = ((latch_reg & ~latch_clr) | latch_set) & intc_pkg::LATCH_MASK;
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      latch_reg <= intc_pkg::WORD_RESET;
    end else begin
      latch_reg <= latch_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Enable flags and master enable

  logic [31:0] enable_reg;
  logic [31:0] enable_next;
  logic        master_reg;
  logic        master_next;
  logic        saved_reg;
  logic        saved_next;
  logic [31:0] wr_en_word;
  logic [31:0] wr_en_lane;

  always_comb begin
    wr_en_word = lane_of(sfr_addr, intc_pkg::ADDR_EN_LO_L, intc_pkg::ADDR_EN_LO_H,
                         intc_pkg::ADDR_EN_HI_L, intc_pkg::ADDR_EN_HI_H,
                         sfr_wdata, 8'h00);
    wr_en_lane = lane_of(sfr_addr, intc_pkg::ADDR_EN_LO_L, intc_pkg::ADDR_EN_LO_H,
                         intc_pkg::ADDR_EN_HI_L, intc_pkg::ADDR_EN_HI_H,
                         8'hff, 8'h00);
    enable_next = enable_reg;
    master_next = master_reg;
    saved_next  = saved_reg;
    if (sfr_wr && en_sel) begin
      enable_next = ((enable_reg & ~wr_en_lane) | (wr_en_word & wr_en_lane))
                    & intc_pkg::ENABLE_MASK;
      if (wr_en_lane[intc_pkg::MASTER_BIT]) begin
        master_next = wr_en_word[intc_pkg::MASTER_BIT];
      end
    end
    if (unmask_all_instr) begin
      master_next = 1'b1;
    end else if (mask_all_instr) begin
      master_next = 1'b0;
    end
    if (return_instr) begin
      master_next = restored_master;
    end
    // Acceptance outranks every other source of change to the master flag.
    if (accept) begin
      saved_next  = master_reg;
      master_next = 1'b0;
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      enable_reg <= intc_pkg::WORD_RESET;
      master_reg <= 1'b0;
      saved_reg  <= 1'b0;
    end else begin
      enable_reg <= enable_next;
      master_reg <= master_next;
      saved_reg  <= saved_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Eligibility and priority

  logic [31:0]               eligible;
  logic                      pick_any;
  logic [intc_pkg::IDX_W-1:0] pick_idx;

  always_comb begin
    eligible = latch_reg & enable_reg & {32{master_reg}};
    eligible[intc_pkg::IDX_SWI]   = swi_req;
    eligible[intc_pkg::IDX_UNDEF] = undef_req;
    eligible[intc_pkg::IDX_TRAP]  = latch_reg[intc_pkg::IDX_TRAP];
    eligible[intc_pkg::IDX_WDT]   = latch_reg[intc_pkg::IDX_WDT];
  end

  priority_pick u_pick (
    .eligible (eligible),
    .any      (pick_any),
    .index    (pick_idx)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Acceptance window in machine cycles

  logic [3:0] busy_cnt_reg;
  logic [3:0] busy_cnt_next;

  always_comb begin
    busy_cnt_next = busy_cnt_reg;
    if (accept) begin
      busy_cnt_next = intc_pkg::ACCEPT_MACHINE_CYCLES;
    end else if (machine_cycle_tick && (busy_cnt_reg != 4'h0)) begin
      busy_cnt_next = busy_cnt_reg - 4'h1;
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      busy_cnt_reg <= 4'h0;
    end else begin
      busy_cnt_reg <= busy_cnt_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Request outputs

  logic                       req_reg;
  logic                       req_next;
  logic [intc_pkg::IDX_W-1:0] idx_reg;
  logic [intc_pkg::IDX_W-1:0] idx_next;
  logic                       samp_reg;
  logic                       samp_next;
  logic [intc_pkg::IDX_W-1:0] samp_idx_reg;
  logic [intc_pkg::IDX_W-1:0] samp_idx_next;

  // The live request is refreshed every cycle; the sampled copy is frozen per instruction.
  always_comb begin
    req_next      = pick_any;
    idx_next      = pick_idx;
    samp_next     = samp_reg;
    samp_idx_next = samp_idx_reg;
    if (accept) begin
      samp_next = 1'b0;
    end else if (instr_last_cycle && (busy_cnt_reg == 4'h0)) begin
      samp_next     = pick_any;
      samp_idx_next = pick_idx;
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      req_reg      <= 1'b0;
      idx_reg      <= intc_pkg::IDX_SWI;
      samp_reg     <= 1'b0;
      samp_idx_reg <= intc_pkg::IDX_SWI;
    end else begin
      req_reg      <= req_next;
      idx_reg      <= idx_next;
      samp_reg     <= samp_next;
      samp_idx_reg <= samp_idx_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Read data

  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic [31:0] en_view;

  always_comb begin
    en_view = enable_reg;
    en_view[intc_pkg::MASTER_BIT] = master_reg;
    rdata_next = rdata_reg;
    if (sfr_rd && pend_sel) begin
      rdata_next = pick_byte(sfr_addr, intc_pkg::ADDR_PEND_LO_L, intc_pkg::ADDR_PEND_LO_H,
                             intc_pkg::ADDR_PEND_HI_L, intc_pkg::ADDR_PEND_HI_H,
                             latch_reg);
    end else if (sfr_rd && en_sel) begin
      rdata_next = pick_byte(sfr_addr, intc_pkg::ADDR_EN_LO_L, intc_pkg::ADDR_EN_LO_H,
                             intc_pkg::ADDR_EN_HI_L, intc_pkg::ADDR_EN_HI_H,
                             en_view);
    end else if (sfr_rd) begin
      rdata_next = 8'h00;
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rdata_reg <= 8'h00;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Output drive

  assign sfr_rdata         = rdata_reg;
  assign sfr_hit           = pend_sel | en_sel;
  assign irq_request       = req_reg;
  assign irq_index         = idx_reg;
  assign irq_sampled       = samp_reg;
  assign irq_sampled_index = samp_idx_reg;
  assign saved_master      = saved_reg;
  assign accept_busy       = (busy_cnt_reg != 4'h0);
  assign master_enable     = master_reg;

endmodule

// *** include/intc_pkg.sv ***
// Overview of operation
// - Every source has a pending latch except software and undefined-instruction interrupts.
// - A request sets its latch; a maskable source asks the core only when enabled.
// - Accepting a source clears its pending latch at once.
// - Reset forces every pending latch to zero.
// - Pending latches appear as four bytes at 002EH, 002FH, 003CH, 003DH.
// - Writing zero clears that latch bit; writing one leaves it unchanged.
// - No write can set a latch; only a hardware request can.
// - Pending latches are readable so software can poll requests.
// - Software, undefined, trap and watchdog interrupts ignore the enable register.
// - Enable bytes at 002CH, 002DH, 003AH, 003BH are fully read/write; here bits 1-3 of 003AH read zero and bit 0 is master enable.
// - Master enable at zero blocks every maskable interrupt.
// - With master enable set, a maskable source also needs its flag.
// - On acceptance, master enable is saved to stack, then cleared.
// - Either return instruction reloads master enable from the saved value.
// - Master enable is bit 0 of the low enable byte at 003AH.
// - Unmask-all sets, mask-all clears master enable; reset clears it.
// - An enable bit at one permits its source, at zero blocks it.
// - Reset clears all individual enable flags to zero.
// - Simultaneous eligible requests are taken in fixed hardware priority order.
// - Requests are sampled in the final cycle of each instruction.
// - Acceptance takes eight machine cycles after the instruction completes.
package intc_pkg;

  localparam int unsigned NUM_SRC   = 32;
  localparam int unsigned IDX_W     = 5;

  // Source index assignment; a lower index has higher priority.
  localparam logic [IDX_W-1:0] IDX_SWI   = 5'h00;
  localparam logic [IDX_W-1:0] IDX_UNDEF = 5'h01;
  localparam logic [IDX_W-1:0] IDX_TRAP  = 5'h02;
  localparam logic [IDX_W-1:0] IDX_WDT   = 5'h03;
  localparam int unsigned      FIRST_MASKABLE = 4;

  // Byte addresses in the special-function area.
  localparam logic [7:0] ADDR_EN_HI_L   = 8'h2c;
  localparam logic [7:0] ADDR_EN_HI_H   = 8'h2d;
  localparam logic [7:0] ADDR_PEND_HI_L = 8'h2e;
  localparam logic [7:0] ADDR_PEND_HI_H = 8'h2f;
  localparam logic [7:0] ADDR_EN_LO_L   = 8'h3a;
  localparam logic [7:0] ADDR_EN_LO_H   = 8'h3b;
  localparam logic [7:0] ADDR_PEND_LO_L = 8'h3c;
  localparam logic [7:0] ADDR_PEND_LO_H = 8'h3d;

  localparam int unsigned MASTER_BIT = 0;

  // Bits that hold real state in the 32-bit latch and enable words.
  localparam logic [31:0] LATCH_MASK  = 32'hffff_fffc;
  localparam logic [31:0] ENABLE_MASK = 32'hffff_fff0;
  localparam logic [31:0] WORD_RESET  = 32'h0000_0000;

  localparam logic [3:0] ACCEPT_MACHINE_CYCLES = 4'h8;

endpackage

// *** verilog/priority_pick.sv ***
`timescale 1ns/10ps
module priority_pick (
  // Eligible sources, bit 0 is the highest priority
  input  wire logic [intc_pkg::NUM_SRC-1:0] eligible,
  // Result
  output logic                               any,
  output logic [intc_pkg::IDX_W-1:0]         index
);

  always_comb begin
    any   = 1'b0;
    index = intc_pkg::IDX_SWI;
    for (int i = intc_pkg::NUM_SRC - 1; i >= 0; i--) begin
      if (eligible[i]) begin
        any   = 1'b1;
        index = i[intc_pkg::IDX_W-1:0];
      end
    end
  end

endmodule

// *** tb/interrupt_latch_enable_unit_monitor.sv ***
`timescale 1ns/10ps
module ilu_monitor (
  // Clock, reset and byte access
  input wire logic                       sys_clk,
  input wire logic                       sys_rst,
  input wire logic [7:0]                 sfr_addr,
  input wire logic                       sfr_wr,
  input wire logic                       sfr_rd,
  input wire logic [7:0]                 sfr_rdata,
  input wire logic                       sfr_hit,
  // Sources and core side
  input wire logic                       swi_req,
  input wire logic                       accept,
  input wire logic                       return_instr,
  input wire logic                       restored_master,
  input wire logic                       unmask_all_instr,
  input wire logic                       mask_all_instr,
  input wire logic                       instr_last_cycle,
  // Results
  input wire logic                       irq_request,
  input wire logic [intc_pkg::IDX_W-1:0] irq_index,
  input wire logic                       irq_sampled,
  input wire logic [intc_pkg::IDX_W-1:0] irq_sampled_index,
  input wire logic                       saved_master,
  input wire logic                       accept_busy,
  input wire logic                       master_enable
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  ////////////////////////////////////////
  sequence s_take;
    accept;
  endsequence
  sequence s_ret;
    return_instr && !accept;
  endsequence
  a_reset_clears: assert property ($fell(sys_rst) |-> !master_enable && !irq_request)
    else $error("state not clear after reset");
  a_unmask_sets: assert property (unmask_all_instr && !accept && !return_instr && !sfr_wr
    |=> master_enable) else $error("unmask ignored");
  a_mask_clears: assert property (mask_all_instr && !unmask_all_instr && !return_instr
    && !sfr_wr |=> !master_enable) else $error("mask ignored");
  a_accept_saves: assert property (s_take |=> !master_enable && accept_busy
    && saved_master == $past(master_enable)) else $error("accept did not save master");
  a_return_loads: assert property (s_ret |=> master_enable == $past(restored_master))
    else $error("return did not restore master");
  a_masked_blocked: assert property (irq_request && irq_index >= intc_pkg::FIRST_MASKABLE
    |-> $past(master_enable)) else $error("maskable request with master off");
  a_swi_first: assert property (swi_req |=> irq_request && irq_index == 5'h00)
    else $error("software request not presented first");
  a_sample_taken: assert property (instr_last_cycle && !accept && !accept_busy
    |=> irq_sampled == irq_request && irq_sampled_index == irq_index)
    else $error("final-cycle sample not taken");
  a_sample_held: assert property (!instr_last_cycle && !accept
    |=> $stable(irq_sampled) && $stable(irq_sampled_index))
    else $error("sampled request moved mid-instruction");
  a_unmapped_zero: assert property (sfr_rd && !sfr_hit |=> sfr_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_hit_decode: assert property (sfr_hit == (sfr_addr inside {8'h2c, 8'h2d, 8'h2e,
    8'h2f, 8'h3a, 8'h3b, 8'h3c, 8'h3d})) else $error("byte decode wrong");
endmodule

// *** tb/core_seq_model.sv ***
`timescale 1ns/10ps
module core_seq_model (
  // Clock, reset and pace
  input  wire logic                       sys_clk,
  input  wire logic                       sys_rst,
  input  wire logic                       slow,
  // From the unit
  input  wire logic                       irq_sampled,
  input  wire logic [intc_pkg::IDX_W-1:0] irq_sampled_index,
  input  wire logic                       saved_master,
  input  wire logic                       accept_busy,
  // To the unit
  output logic                            instr_last_cycle,
  output logic                            machine_cycle_tick,
  output logic                            accept,
  output logic [intc_pkg::IDX_W-1:0]      accept_index,
  output logic                            return_instr,
  output logic                            restored_master
);
  logic [3:0] cnt = '0;
  logic       push = '0;
  logic       take;
  int         svc = 0;
  logic       stack [$];
  initial begin
    {instr_last_cycle, machine_cycle_tick, accept, return_instr, restored_master} = '0;
    accept_index = '0;
  end
  ////////////////////////////////////////
  // Index and restore lines toggle when idle, so the unit must not use them then.
  assign take = irq_sampled && !accept_busy && !accept;
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      svc <= 0;
      accept <= 1'h0;
      return_instr <= 1'h0;
      stack.delete();
    end else begin
      cnt <= cnt + 4'h1;
      machine_cycle_tick <= cnt[1:0] == 2'h3;
      instr_last_cycle <= slow ? cnt == 4'hf : cnt[0];
      accept <= take;
      accept_index <= take ? irq_sampled_index : ~accept_index;
      push <= accept;
      if (push) begin
        stack.push_back(saved_master);
      end
      if (accept) begin
        svc <= slow ? 40 : 12;
      end else if (svc > 0 && !accept_busy) begin
        svc <= svc - 1;
      end
      if (svc == 1 && !accept_busy && !accept && stack.size() > 0) begin
        return_instr <= 1'h1;
        restored_master <= stack.pop_back();
      end else begin
        return_instr <= 1'h0;
        restored_master <= ~restored_master;
      end
    end
  end
endmodule

// *** tb/interrupt_latch_enable_unit_bench.sv ***
`timescale 1ns/10ps
module interrupt_latch_enable_unit_bench;
  logic sys_clk = '0, sys_rst = 1'h1, sfr_wr = '0, sfr_rd = '0, swi_req = '0;
  logic undef_req = '0, unmask_all_instr = '0, mask_all_instr = '0, slow = '0;
  logic sfr_hit, irq_request, irq_sampled, saved_master, accept_busy, master_enable;
  logic instr_last_cycle, machine_cycle_tick, accept, return_instr, restored_master;
  logic [7:0] sfr_addr = '0, sfr_wdata = '0, sfr_rdata, w;
  logic [31:0] src_req = '0, lat;
  logic [intc_pkg::IDX_W-1:0] accept_index, irq_index, irq_sampled_index;
  logic [7:0] ea [4] = '{8'h2c, 8'h2d, 8'h3a, 8'h3b};
  logic [7:0] pa [4] = '{8'h3c, 8'h3d, 8'h2e, 8'h2f};
  int n_mismatch = 0, comparisons = 0, k1, k2;
  always #2.5 sys_clk = ~sys_clk;
  interrupt_latch_enable_unit i_dut (.*);
  core_seq_model i_core (.*);
  ////////////////////////////////////////
  task automatic tick(int n = 1);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic chk(string n, logic [7:0] e, s);
    comparisons++;
    if (s !== e) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic chkb(string n, logic e, s);
    chk(n, {7'h00, e}, {7'h00, s});
  endtask
  task automatic wr(logic [7:0] a, d);
    tick();
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'h1;
    tick();
    sfr_wr = 1'h0;
  endtask
  task automatic rd(logic [7:0] a, e);
    tick();
    sfr_addr = a;
    sfr_rd = 1'h1;
    tick();
    sfr_rd = 1'h0;
    chk("sfr_rdata", e, sfr_rdata);
  endtask
  task automatic pulse(ref logic s);
    s = 1'h1;
    tick();
    s = 1'h0;
  endtask
  task automatic wait_hi(ref logic s);
    int n;
    for (n = 0; n < 300 && s !== 1'h1; n++) tick();
    if (n == 300) chk("handshake", 8'h01, 8'h00);
  endtask
  // The lowest set position wins, so the first one found is the expected index.
  function automatic logic [7:0] first(logic [31:0] v);
    for (int i = 0; i < 32; i++) if (v[i]) return 8'(i);
    return 8'h00;
  endfunction
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  ////////////////////////////////////////
  initial begin
    void'($urandom(32'hec25));
    tick(5);
    sys_rst = 1'h0;
    foreach (pa[i]) rd(pa[i], 8'h00);
    foreach (ea[i]) rd(ea[i], 8'h00);
    rd(8'h30, 8'h00);
    foreach (ea[i]) begin
      w = 8'($urandom()) & (i == 2 ? 8'hfe : 8'hff);
      wr(ea[i], w);
      rd(ea[i], w & (i == 2 ? 8'hf0 : 8'hff));
    end
    lat = $urandom() & 32'hffff_fff3;
    src_req = lat;
    tick();
    src_req = '0;
    lat &= intc_pkg::LATCH_MASK;
    foreach (pa[i]) rd(pa[i], lat[8*i +: 8]);
    foreach (pa[i]) begin
      w = 8'($urandom()) | 8'h0c;
      wr(pa[i], w);
      lat[8*i +: 8] &= w;
    end
    foreach (pa[i]) rd(pa[i], lat[8*i +: 8]);
    foreach (pa[i]) wr(pa[i], i == 0 ? 8'h0c : 8'h00);
    foreach (ea[i]) wr(ea[i], i == 2 ? 8'hf0 : 8'hff);
    wr(ea[2], 8'hf1);
    chkb("master_enable", 1'h1, master_enable);
    rd(ea[2], 8'hf1);
    pulse(mask_all_instr);
    rd(ea[2], 8'hf0);
    k1 = 4 + $urandom_range(26);
    k2 = k1 + 1 + $urandom_range(30 - k1);
    lat = (32'h1 << k1) | (32'h1 << k2);
    slow = 1'h1;
    src_req = lat;
    tick();
    src_req = '0;
    tick(8);
    chkb("irq_request", 1'h0, irq_request);
    pulse(unmask_all_instr);
    wait_hi(irq_request);
    chk("irq_index", first(lat), 8'(irq_index));
    wait_hi(accept);
    tick();
    chkb("master_enable", 1'h0, master_enable);
    lat[k1] = 1'h0;
    foreach (pa[i]) rd(pa[i], lat[8*i +: 8]);
    // Flag changes inside the handler are done before the return sets the master again.
    wr(ea[2], 8'hf0);
    rd(ea[2], 8'hf0);
    repeat (2) begin
      wait_hi(return_instr);
      tick();
      chkb("master_enable", 1'h1, master_enable);
    end
    pulse(mask_all_instr);
    wr(ea[(k1 / 8 + 2) % 4], 8'h00);
    pulse(unmask_all_instr);
    lat = 32'h1 << k1;
    src_req = lat;
    tick();
    src_req = '0;
    tick(8);
    chkb("irq_request", 1'h0, irq_request);
    pulse(mask_all_instr);
    slow = 1'h0;
    for (int i = 0; i < 4; i++) begin
      tick();
      swi_req = i == 0;
      undef_req = i == 1;
      src_req = i > 1 ? 32'h1 << i : '0;
      tick();
      src_req = '0;
      wait_hi(irq_request);
      chk("irq_index", 8'(i), 8'(irq_index));
      wait_hi(accept);
      swi_req = 1'h0;
      undef_req = 1'h0;
      wait_hi(return_instr);
    end
    rd(8'h3c, lat[7:0]);
    stop_test();
  end
  initial begin
    #100us;
    n_mismatch++;
    stop_test();
  end
endmodule
bind interrupt_latch_enable_unit ilu_monitor i_mon (.*);
